// ### logic/ceds_core.sv
// ceds_core: CAN error detection, error counters, error state and the
// phase-2 / wake-up / clock-out configuration register, APB slave.
// assumes a frame sequencer delivers each sampled bit with its field,
// and builds the error frames and retries on the requests given here.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module ceds_core
   import ceds_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // bit stream from the frame sequencer
   input  ceds_bit_t        bit_in,
   // clock output sources
   input  wire logic        sof_pulse,
   input  wire logic        clk_div,
   // requests to the frame sequencer
   output logic             tx_crc_bit,
   output logic             err_frame_req,
   output logic             err_frame_dominant,
   output logic             tx_abort,
   output logic             retransmit_req,
   output logic             bus_enable,
   // configuration outputs
   output logic             clock_output_pin,
   output logic             wake_filter_enable,
   output logic             phase2_length_source,
   output logic [2:0]       phase2_seg_len,
   // state
   output ceds_state_t      err_state
);

   // register state
   logic [7:0]   btc_r, btc_nxt;            // configuration register
   logic         clken_r, clken_nxt;        // clock_output_enable
   logic         btl_r, btl_nxt;            // phase2_length_source
   err_vec_t     sticky_r, sticky_nxt;      // sticky error flags
   logic [31:0]  prdata_r, prdata_nxt;      // read data
   logic         slverr_nxt;                // unmapped address answer

   // detection state
   logic [CRC_W-1:0] crc_calc;              // running checksum
   logic [CRC_W-1:0] tx_sh_r, tx_sh_nxt;    // checksum being sent
   logic [CRC_W-1:0] rx_sh_r, rx_sh_nxt;    // checksum being received
   logic [2:0]       run_r, run_nxt;        // equal-polarity run length
   logic             last_r, last_nxt;      // previous bus level
   err_vec_t         err;                   // errors seen this strobe
   logic             any_err;               // any error this strobe

   // error state
   logic [8:0]   tec_r, tec_nxt;            // transmit_error_count
   logic [8:0]   rec_r, rec_nxt;            // receive_error_count
   ceds_state_t  state_r, state_nxt;        // current error state
   logic [3:0]   idle_bits_r, idle_bits_nxt;// recessive run in bus-off
   logic [7:0]   idle_runs_r, idle_runs_nxt;// completed runs in bus-off

   // output flops
   logic         efr_r, efr_nxt;            // error frame request
   logic         abort_r, abort_nxt;        // transmit abort
   logic         retry_r, retry_nxt;        // retry request
   logic         clock_output_pin_r, clock_output_pin_nxt;      // clock output pin

   // apb access qualifiers and bit-stream field decodes
   logic         wr_en, rd_en;
   logic         in_crc_span;               // fields covered by the checksum
   logic         in_stuff_span;             // fields with stuffing
   logic         cnt_bit;                   // bit counted by checksum

   assign wr_en  = psel & penable & pwrite;
   assign rd_en  = psel & ~penable & ~pwrite;  // latch read data in setup

   // checksum covers start-of-frame through data, stuff bits excluded
   assign in_crc_span = (bit_in.field == FLD_SOF) | (bit_in.field == FLD_ARB) |
                        (bit_in.field == FLD_CTRL) | (bit_in.field == FLD_DATA);
   assign in_stuff_span = in_crc_span | (bit_in.field == FLD_CRC);
   assign cnt_bit = bit_in.strobe & ~bit_in.stuff_bit & in_crc_span;

   // shared checksum: both directions read back the bus level
   ceds_crc15 u_crc (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (bit_in.field == FLD_IDLE),
      .en      (cnt_bit),
      .din     (bit_in.rx),
      .crc     (crc_calc)
   );

   // error detection on each sample strobe outside bus-off
   always_comb begin
      err        = '0;
      run_nxt    = run_r;
      last_nxt   = last_r;
      tx_sh_nxt  = tx_sh_r;
      rx_sh_nxt  = rx_sh_r;
      if (bit_in.field != FLD_CRC) begin
         tx_sh_nxt = crc_calc;
      end
      if (bit_in.strobe && state_r != ST_BUSOFF) begin
         // checksum field shifting, stuff bits skipped
         if (bit_in.field == FLD_CRC && !bit_in.stuff_bit) begin
            tx_sh_nxt = {tx_sh_r[CRC_W-2:0], 1'b0};
            rx_sh_nxt = {rx_sh_r[CRC_W-2:0], bit_in.rx};
         end
         // receiver compares at the delimiter
         if (bit_in.field == FLD_CRC_DELIM && !bit_in.transmitting) begin
            err.crc = (rx_sh_r != crc_calc);
         end
         // acknowledge missing
         err.ack = bit_in.transmitting & (bit_in.field == FLD_ACK_SLOT)
                   & bit_in.rx;
         // dominant in a fixed-form field
         err.form = ~bit_in.rx & ((bit_in.field == FLD_CRC_DELIM) |
                    (bit_in.field == FLD_ACK_DELIM) | (bit_in.field == FLD_EOF) |
                    (bit_in.field == FLD_IFS));
         // readback mismatch, arbitration loss and ack excepted
         if (bit_in.transmitting && bit_in.rx != bit_in.tx && in_stuff_span |
             (bit_in.field == FLD_ACK_SLOT) | (bit_in.field == FLD_CRC_DELIM)) begin
            err.bitl = ~(bit_in.tx & ~bit_in.rx &
                       ((bit_in.field == FLD_ARB) |
                        (bit_in.field == FLD_ACK_SLOT)));
         end
         // stuffing rule check
         if (bit_in.field == FLD_SOF) begin
            run_nxt  = 3'h1;
            last_nxt = bit_in.rx;
         end else if (in_stuff_span) begin
            last_nxt = bit_in.rx;
            if (bit_in.rx == last_r) begin
               run_nxt = run_r + 3'h1;
               err.stuff = (run_r + 3'h1 == STUFF_LIMIT);
            end else begin
               run_nxt = 3'h1;
            end
         end
      end
      any_err = |err;
   end

   // counters and error state
   always_comb begin
      tec_nxt       = tec_r;
      rec_nxt       = rec_r;
      state_nxt     = state_r;
      idle_bits_nxt = idle_bits_r;
      idle_runs_nxt = idle_runs_r;
      efr_nxt       = 1'b0;
      abort_nxt     = 1'b0;
      retry_nxt     = 1'b0;
      if (state_r == ST_BUSOFF) begin
         // count runs of eleven recessive bits
         if (bit_in.strobe) begin
            if (!bit_in.rx) begin
               idle_bits_nxt = '0;
            end else if (idle_bits_r + 4'h1 == IDLE_RUN_LEN) begin
               idle_bits_nxt = '0;
               idle_runs_nxt = idle_runs_r + 8'h1;
            end else begin
               idle_bits_nxt = idle_bits_r + 4'h1;
            end
         end
         if (idle_runs_r == IDLE_RUN_CNT) begin
            tec_nxt       = '0;
            rec_nxt       = '0;
            idle_runs_nxt = '0;
            state_nxt     = ST_ACTIVE;
         end
      end else begin
         if (any_err) begin
            efr_nxt = 1'b1;
            if (bit_in.transmitting) begin
               abort_nxt = 1'b1;
               retry_nxt = 1'b1;
               tec_nxt   = tec_r + TX_ERR_STEP;
            end else if (rec_r < CNT_MAX) begin
               rec_nxt = rec_r + RX_ERR_STEP;
            end
         end else if (bit_in.frame_ok) begin
            if (bit_in.transmitting && tec_r != '0) begin
               tec_nxt = tec_r - 9'h001;
            end else if (!bit_in.transmitting && rec_r != '0) begin
               rec_nxt = rec_r - 9'h001;
            end
         end
         // thresholds applied to the updated counts
         if (tec_nxt > BUSOFF_LIMIT) begin
            state_nxt     = ST_BUSOFF;
            idle_bits_nxt = '0;
            idle_runs_nxt = '0;
         end else if (tec_nxt >= PASSIVE_LIMIT || rec_nxt >= PASSIVE_LIMIT) begin
            state_nxt = ST_PASSIVE;
         end else begin
            state_nxt = ST_ACTIVE;
         end
      end
   end

   // apb register next values
   always_comb begin
      btc_nxt    = btc_r;
      clken_nxt  = clken_r;
      btl_nxt    = btl_r;
      prdata_nxt = prdata_r;
      slverr_nxt = 1'b1;
      // hardware set wins over software clear
      sticky_nxt = sticky_r;
      if (wr_en && paddr == OFS_STATUS) begin
         sticky_nxt = sticky_r & ~pwdata[ST_ERR_LSB +: 5];
      end
      sticky_nxt = sticky_nxt | err;
      unique case (paddr)
         OFS_BTC: begin
            slverr_nxt = 1'b0;
            if (wr_en) begin
               btc_nxt = pwdata[7:0] & BTC_WMASK;
            end
            prdata_nxt = {24'h000000, btc_r};
         end
         OFS_STATUS: begin
            slverr_nxt = 1'b0;
            prdata_nxt = {9'h000, sticky_r, state_r,
                          rec_r[7:0], tec_r[7:0]};
         end
         OFS_CTRL: begin
            slverr_nxt = 1'b0;
            if (wr_en) begin
               clken_nxt = pwdata[CTRL_CLKEN_BIT];
               btl_nxt   = pwdata[CTRL_BTL_BIT];
            end
            prdata_nxt = {30'h00000000, btl_r, clken_r};
         end
         default: begin
            prdata_nxt = 32'h00000000;
         end
      endcase
      if (!rd_en) begin
         prdata_nxt = prdata_r;
      end
   end

   // clock output pin function
   always_comb begin
      clock_output_pin_nxt = 1'b0;
      if (clken_r) begin
         clock_output_pin_nxt = btc_r[BTC_SOF_BIT] ? sof_pulse : clk_div;
      end
   end

   // register all groups
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btc_r       <= BTC_RESET;
         clken_r     <= 1'b0;
         btl_r       <= 1'b0;
         sticky_r    <= '0;
         prdata_r    <= 32'h00000000;
         tx_sh_r     <= '0;
         rx_sh_r     <= '0;
         run_r       <= '0;
         last_r      <= 1'b1;
         tec_r       <= '0;
         rec_r       <= '0;
         state_r     <= ST_ACTIVE;
         idle_bits_r <= '0;
         idle_runs_r <= '0;
         efr_r       <= 1'b0;
         abort_r     <= 1'b0;
         retry_r     <= 1'b0;
         clock_output_pin_r    <= 1'b0;
      end else begin
         btc_r       <= btc_nxt;
         clken_r     <= clken_nxt;
         btl_r       <= btl_nxt;
         sticky_r    <= sticky_nxt;
         prdata_r    <= prdata_nxt;
         tx_sh_r     <= tx_sh_nxt;
         rx_sh_r     <= rx_sh_nxt;
         run_r       <= run_nxt;
         last_r      <= last_nxt;
         tec_r       <= tec_nxt;
         rec_r       <= rec_nxt;
         state_r     <= state_nxt;
         idle_bits_r <= idle_bits_nxt;
         idle_runs_r <= idle_runs_nxt;
         efr_r       <= efr_nxt;
         abort_r     <= abort_nxt;
         retry_r     <= retry_nxt;
         clock_output_pin_r    <= clock_output_pin_nxt;
      end
   end

   // slave answers in the first access cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & slverr_nxt;
   assign prdata  = prdata_r;

   // outputs
   assign tx_crc_bit         = tx_sh_r[CRC_W-1];
   assign err_frame_req      = efr_r;
   assign err_frame_dominant = (state_r == ST_ACTIVE);
   assign tx_abort           = abort_r;
   assign retransmit_req     = retry_r;
   assign bus_enable         = (state_r != ST_BUSOFF);
   assign clock_output_pin   = clock_output_pin_r;
   assign wake_filter_enable = btc_r[BTC_WAKE_BIT];
   assign phase2_length_source = btl_r;
   // field only meaningful with the source bit; zero otherwise
   assign phase2_seg_len     = btl_r ? btc_r[2:0] : 3'h0;
   assign err_state          = state_r;

endmodule : ceds_core

// ### logic/ceds_crc15.sv
// ceds_crc15: serial 15-bit CAN checksum register.
// assumes en pulses once per counted bit; clear wins over en.
`timescale 1ns/10ps
module ceds_crc15
   import ceds_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // bit stream
   input  wire logic             clear,
   input  wire logic             en,
   input  wire logic             din,
   // result
   output logic [CRC_W-1:0]      crc
);

   logic [CRC_W-1:0] crc_r;    // running remainder
   logic [CRC_W-1:0] crc_nxt;  // next remainder
   logic             fb;       // feedback bit

   // shift with polynomial feedback
   always_comb begin
      fb      = din ^ crc_r[CRC_W-1];
      crc_nxt = crc_r;
      if (clear) begin
         crc_nxt = '0;
      end else if (en) begin
         crc_nxt = {crc_r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
   end

   // register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_r <= '0;
      end else begin
         crc_r <= crc_nxt;
      end
   end

   assign crc = crc_r;

endmodule : ceds_crc15

// ### logic/ceds_pkg.sv
// ceds_pkg: shared constants, types and register map of the CAN error
// detection and error state block.
// assumes one 200 MHz clock and an APB register bus with 32-bit data.
package ceds_pkg;

   // clock
   localparam int CLK_MHZ = 200;                // pclk rate

   // register byte offsets
   localparam logic [11:0] OFS_BTC    = 12'h028;  // bit_timing_phase2_wake_ctrl
   localparam logic [11:0] OFS_STATUS = 12'h02C;  // counters, state, sticky errors
   localparam logic [11:0] OFS_CTRL   = 12'h030;  // clock out enable, phase-2 source

   // bit_timing_phase2_wake_ctrl layout
   localparam int          BTC_SOF_BIT  = 7;      // clock out function select
   localparam int          BTC_WAKE_BIT = 6;      // wake-up filter enable
   localparam logic [7:0]  BTC_WMASK    = 8'hC7;  // bits 5..3 unimplemented
   localparam logic [7:0]  BTC_RESET    = 8'h00;  // all fields clear at reset

   // control register layout
   localparam int          CTRL_CLKEN_BIT = 0;    // clock_output_enable
   localparam int          CTRL_BTL_BIT   = 1;    // phase2_length_source

   // status register layout
   localparam int          ST_TEC_LSB   = 0;      // transmit_error_count
   localparam int          ST_REC_LSB   = 8;      // receive_error_count
   localparam int          ST_STATE_LSB = 16;     // error state code, 2 bits
   localparam int          ST_ERR_LSB   = 18;     // sticky error flags, 5 bits

   // error thresholds and counter steps
   localparam logic [8:0]  PASSIVE_LIMIT = 9'h080;  // 128
   localparam logic [8:0]  BUSOFF_LIMIT  = 9'h0FF;  // off when above 255
   localparam logic [8:0]  TX_ERR_STEP   = 9'h008;  // transmitter penalty
   localparam logic [8:0]  RX_ERR_STEP   = 9'h001;  // receiver penalty
   localparam logic [8:0]  CNT_MAX       = 9'h0FF;  // receive counter ceiling
   localparam logic [3:0]  IDLE_RUN_LEN  = 4'hB;    // 11 recessive bits
   localparam logic [7:0]  IDLE_RUN_CNT  = 8'h80;   // 128 such runs
   localparam logic [2:0]  STUFF_LIMIT   = 3'h6;    // six equal bits

   // crc
   localparam int          CRC_W    = 15;
   localparam logic [14:0] CRC_POLY = 15'h4599;

   // error flag positions inside err_vec_t
   typedef struct packed {
      logic crc;     // checksum mismatch
      logic ack;     // ack slot stayed recessive
      logic form;    // dominant in a fixed-form field
      logic bitl;    // sampled level differs from driven level
      logic stuff;   // six equal bits
   } err_vec_t;

   // field currently on the bus, reported by the frame sequencer
   typedef enum logic [3:0] {
      FLD_IDLE, FLD_SOF, FLD_ARB, FLD_CTRL, FLD_DATA, FLD_CRC, FLD_CRC_DELIM,
      FLD_ACK_SLOT, FLD_ACK_DELIM, FLD_EOF, FLD_IFS, FLD_ERRFRM
   } ceds_field_t;

   // one sampled bit with its context
   typedef struct packed {
      logic        strobe;        // sample point pulse
      logic        rx;            // sampled bus level, 1 = recessive
      logic        tx;            // level being driven
      logic        transmitting;  // we own this frame
      logic        stuff_bit;     // bit is a stuff bit
      logic        frame_ok;      // pulse: frame ended without error
      ceds_field_t field;         // current field
   } ceds_bit_t;

   typedef enum logic [1:0] {ST_ACTIVE, ST_PASSIVE, ST_BUSOFF} ceds_state_t;

endpackage : ceds_pkg

// ### test/ceds_bus_node.sv
// ceds_bus_node: behavioural stand-in for the other nodes, handing one
// sampled bit at a time to the error block.
// assumes each call starts right after a rising pclk edge.
`timescale 1ns/10ps
module ceds_bus_node
   import ceds_pkg::*;
(
   // clock
   input  wire logic pclk,
   // sampled bit stream
   output ceds_bit_t bit_out
);
   // quiet recessive bus until the first bit
   initial bit_out = '{strobe: 1'b0, rx: 1'b1, tx: 1'b1, transmitting: 1'b0,
                       stuff_bit: 1'b0, frame_ok: 1'b0, field: FLD_IDLE};

   // one strobe then a gap cycle, so strobes are never adjacent
   task automatic send(input logic rx, input logic tx, input logic xm,
                       input logic sb, input ceds_field_t fld);
      bit_out <= '{strobe: 1'b1, rx: rx, tx: tx, transmitting: xm,
                   stuff_bit: sb, frame_ok: 1'b0, field: fld};
      @(posedge pclk);
      // level between samples is meaningless; show its inverse, not a copy
      bit_out.strobe <= 1'b0;
      bit_out.rx     <= ~rx;
      @(posedge pclk);
   endtask : send
endmodule : ceds_bus_node

// ### test/ceds_core_sva.sv
// ceds_core_sva: port-level checks of the error detection block.
// assumes one pclk domain; bound to ceds_core from the bench top file.
`timescale 1ns/10ps
module ceds_core_sva
   import ceds_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb side
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   // bit stream and answers
   input  ceds_bit_t        bit_in,
   input  wire logic        err_frame_req,
   input  wire logic        err_frame_dominant,
   input  wire logic        tx_abort,
   input  wire logic        retransmit_req,
   input  wire logic        bus_enable,
   input  wire logic        phase2_length_source,
   input  wire logic [2:0]  phase2_seg_len,
   input  ceds_state_t      err_state
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a sampled bit that must be judged; bus-off bits are only counted
   sequence s_judged;
      bit_in.strobe && err_state != ST_BUSOFF;
   endsequence
   // a real data bit of our own frame
   sequence s_own_bit;
      s_judged ##0 (bit_in.transmitting && !bit_in.stuff_bit);
   endsequence
   // full answer of a transmitter to an error
   sequence s_tx_answer;
      err_frame_req && tx_abort && retransmit_req;
   endsequence

   a_bit_error: assert property (s_own_bit ##0
      (bit_in.field == FLD_DATA && bit_in.tx != bit_in.rx) |=> s_tx_answer)
      else $error("bit error not answered");
   a_ack_error: assert property (s_own_bit ##0
      (bit_in.field == FLD_ACK_SLOT && bit_in.tx && bit_in.rx) |=> s_tx_answer)
      else $error("ack error not answered");
   a_form_error: assert property (s_judged ##0 (!bit_in.rx && bit_in.field inside
      {FLD_CRC_DELIM, FLD_ACK_DELIM, FLD_EOF, FLD_IFS}) |=> err_frame_req)
      else $error("form error not answered");
   a_abort_pair: assert property (tx_abort |-> err_frame_req && retransmit_req)
      else $error("abort without error frame or retry");
   a_req_cause: assert property (err_frame_req |-> $past(bit_in.strobe))
      else $error("error frame without a sampled bit");
   a_state_code: assert property (err_state inside {ST_ACTIVE, ST_PASSIVE, ST_BUSOFF})
      else $error("illegal error state");
   a_frame_kind: assert property (err_frame_dominant == (err_state == ST_ACTIVE))
      else $error("error frame polarity unlike state");
   a_busoff_quiet: assert property ((err_state == ST_BUSOFF) [*2]
      |-> !bus_enable && !err_frame_req)
      else $error("bus-off node still active");
   a_seg_gate: assert property (!phase2_length_source |-> phase2_seg_len == 3'h0)
      else $error("phase-2 field used without source bit");
   a_unused_zero: assert property (psel && penable && !pwrite && paddr == OFS_BTC
      |-> prdata[31:3] == 29'h0 || prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0)
      else $error("unimplemented bits read nonzero");
endmodule : ceds_core_sva

// ### test/test_can_error_detect_state.sv
// test_can_error_detect_state: register and error sequence tests.
// assumes ceds_bus_node plays the far nodes; pclk at 200 MHz.
`timescale 1ns/10ps
module test_can_error_detect_state;
   import ceds_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        se, sof_pulse, clk_div, tx_crc_bit, err_frame_req, err_frame_dominant;
   logic        tx_abort, retransmit_req, bus_enable, clock_output_pin;
   logic        wake_filter_enable, phase2_length_source;
   logic [2:0]  phase2_seg_len;
   ceds_bit_t   bit_in;
   ceds_state_t err_state;
   int          errors = 0, tests_run = 0, n_req = 0, n_abort = 0, n_retry = 0;
   localparam logic [18:0] FRAME = 19'h2AAAA;  // sof, id and data bits

   ceds_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_in(bit_in), .sof_pulse(sof_pulse), .clk_div(clk_div),
      .tx_crc_bit(tx_crc_bit), .err_frame_req(err_frame_req),
      .err_frame_dominant(err_frame_dominant), .tx_abort(tx_abort),
      .retransmit_req(retransmit_req), .bus_enable(bus_enable),
      .clock_output_pin(clock_output_pin), .wake_filter_enable(wake_filter_enable),
      .phase2_length_source(phase2_length_source), .phase2_seg_len(phase2_seg_len),
      .err_state(err_state));
   ceds_bus_node node_u (.pclk(pclk), .bit_out(bit_in));

   // 5 ns clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // pulses counted mid-cycle, where they are settled
   always @(negedge pclk) begin
      n_req   += int'(err_frame_req === 1'b1);
      n_abort += int'(tx_abort === 1'b1);
      n_retry += int'(retransmit_req === 1'b1);
   end
   // checksum bits of our own frame, looked at on the taking edge
   always @(posedge pclk) begin
      if (bit_in.strobe && bit_in.transmitting && bit_in.field == FLD_CRC && !bit_in.stuff_bit)
         chk(32'(tx_crc_bit), 32'(bit_in.tx));
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // one apb transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // reference serial checksum, msb first
   function automatic logic [14:0] crc_of(input logic [18:0] b);
      logic [14:0] c;
      logic        nx;
      c = 15'h0000;
      for (int i = 18; i >= 0; i--) begin
         nx = b[i] ^ c[14];
         c  = {c[13:0], 1'b0} ^ (nx ? CRC_POLY : 15'h0000);
      end
      return c;
   endfunction : crc_of
   // whole frame, stuffed; flip spoils the last checksum bit
   task automatic frame(input logic xm, input logic flip);
      logic [33:0] fb;
      logic        last;
      int          run;
      ceds_field_t f;
      fb   = {FRAME, crc_of(FRAME) ^ {14'h0000, flip}};
      last = 1'b1;
      run  = 0;
      for (int i = 33; i >= 0; i--) begin
         f = (i == 33) ? FLD_SOF : (i > 21) ? FLD_ARB : (i > 14) ? FLD_DATA : FLD_CRC;
         // a sixth equal bit would be a stuff error, so break the run first
         if (run == 5) begin
            node_u.send(~last, xm ? ~last : 1'b1, xm, 1'b1, f);
            last = ~last;
            run  = 1;
         end
         run  = (fb[i] == last) ? run + 1 : 1;
         last = fb[i];
         node_u.send(fb[i], xm ? fb[i] : 1'b1, xm, 1'b0, f);
      end
      node_u.send(1'b1, 1'b1, xm, 1'b0, FLD_CRC_DELIM);
      node_u.send(1'b0, 1'b1, xm, 1'b0, FLD_ACK_SLOT);
      node_u.send(1'b1, 1'b1, xm, 1'b0, FLD_ACK_DELIM);
      repeat (7) node_u.send(1'b1, 1'b1, xm, 1'b0, FLD_EOF);
      node_u.send(1'b1, 1'b1, 1'b0, 1'b0, FLD_IDLE);
   endtask : frame

   // watchdog: the run needs about 3250 cycles
   initial begin
      #100000;
      errors++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, sof_pulse, clk_div} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFS_BTC, 32'h0);
      chk(rd, 32'(BTC_RESET));
      chk(32'(err_frame_dominant), 32'h1);
      apb(1'b1, OFS_BTC, 32'hFF);
      apb(1'b0, OFS_BTC, 32'h0);
      chk(rd, 32'hC7);
      chk(32'(wake_filter_enable), 32'h1);
      chk(32'(phase2_seg_len), 32'h0);
      apb(1'b1, OFS_CTRL, 32'h2);
      chk({31'(phase2_seg_len), phase2_length_source}, {31'h7, 1'b1});
      apb(1'b1, OFS_BTC, 32'h01); // two quanta, the shortest legal
      chk(32'(wake_filter_enable), 32'h0);
      sof_pulse <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b1, OFS_BTC, 32'h81);
      @(posedge pclk);
      chk(32'(clock_output_pin), 32'h1);
      sof_pulse <= 1'b0;
      clk_div   <= 1'b1;
      apb(1'b1, OFS_BTC, 32'h01);
      @(posedge pclk);
      chk(32'(clock_output_pin), 32'h1);
      apb(1'b1, OFS_CTRL, 32'h2);
      @(posedge pclk);
      chk(32'(clock_output_pin), 32'h0);
      apb(1'b0, 12'h034, 32'h0);
      chk({rd[30:0], se}, 32'h1);
      // receiver errors, then transmitter errors
      node_u.send(1'b0, 1'b1, 1'b0, 1'b0, FLD_EOF);
      chk(32'(n_req), 32'h1);
      node_u.send(1'b1, 1'b1, 1'b0, 1'b0, FLD_IDLE);
      node_u.send(1'b0, 1'b1, 1'b0, 1'b0, FLD_SOF);
      repeat (4) node_u.send(1'b0, 1'b1, 1'b0, 1'b0, FLD_DATA);
      chk(32'(n_req), 32'h1);
      node_u.send(1'b0, 1'b1, 1'b0, 1'b0, FLD_DATA);
      chk({32'(n_req), 32'(n_abort)}, {32'h2, 32'h0});
      node_u.send(1'b1, 1'b1, 1'b0, 1'b0, FLD_IDLE);
      node_u.send(1'b1, 1'b0, 1'b1, 1'b0, FLD_DATA);
      chk(32'(n_req), 32'h3);
      node_u.send(1'b0, 1'b1, 1'b1, 1'b0, FLD_ARB);
      node_u.send(1'b0, 1'b1, 1'b1, 1'b0, FLD_ACK_SLOT);
      chk(32'(n_req), 32'h3);
      node_u.send(1'b1, 1'b1, 1'b1, 1'b0, FLD_ACK_SLOT);
      chk({32'(n_abort), 32'(n_retry)}, {32'h2, 32'h2});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {9'h000, 5'b01111, 2'b00, 8'h02, 8'h10});
      apb(1'b1, OFS_STATUS, 32'h007C0000);
      // climb to the passive limit and past the bus-off limit
      repeat (13) node_u.send(1'b1, 1'b1, 1'b1, 1'b0, FLD_ACK_SLOT);
      chk(32'(err_state), 32'(ST_ACTIVE));
      node_u.send(1'b1, 1'b1, 1'b1, 1'b0, FLD_ACK_SLOT);
      chk(32'(err_state), 32'(ST_PASSIVE));
      chk(32'(err_frame_dominant), 32'h0);
      repeat (16) node_u.send(1'b1, 1'b1, 1'b1, 1'b0, FLD_ACK_SLOT);
      chk(32'(err_state), 32'(ST_BUSOFF));
      chk(32'(bus_enable), 32'h0);
      node_u.send(1'b0, 1'b1, 1'b0, 1'b0, FLD_EOF);
      chk(32'(n_req), 32'd34);
      repeat (1407) node_u.send(1'b1, 1'b1, 1'b0, 1'b0, FLD_IDLE);
      chk(32'(err_state), 32'(ST_BUSOFF));
      node_u.send(1'b1, 1'b1, 1'b0, 1'b0, FLD_IDLE);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(err_state), 32'(ST_ACTIVE));
      chk(rd & 32'h0003FFFF, 32'h0);
      // checksum sent, received intact, received spoiled
      apb(1'b1, OFS_STATUS, 32'h007C0000);
      frame(1'b1, 1'b0);
      frame(1'b0, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[22]), 32'h0);
      frame(1'b0, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({32'(rd[22]), 32'(n_req)}, {32'h1, 32'd35});
      tally_and_finish();
   end
endmodule : test_can_error_detect_state

bind ceds_core ceds_core_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .bit_in(bit_in),
   .err_frame_req(err_frame_req), .err_frame_dominant(err_frame_dominant),
   .tx_abort(tx_abort), .retransmit_req(retransmit_req), .bus_enable(bus_enable),
   .phase2_length_source(phase2_length_source), .phase2_seg_len(phase2_seg_len),
   .err_state(err_state));
